// ---- verilog/audio_in_pkg.sv ----
package audio_in_pkg;

    // ---------------------------------------------------------------
    // framing and word width selections
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_I2S   = 2'b00,
        FMT_LEFT  = 2'b01,
        FMT_RIGHT = 2'b10
    } fmt_t;

    typedef enum logic [1:0] {
        WID16 = 2'b00,
        WID18 = 2'b01,
        WID20 = 2'b10,
        WID24 = 2'b11
    } width_t;

    // ---------------------------------------------------------------
    // slot geometry
    // ---------------------------------------------------------------
    localparam int SAMPLE_W = 24;
    localparam logic [4:0] MSB_IDX = 5'h17;
    localparam logic [5:0] SLOT_LEN = 6'h20;
    localparam logic [5:0] SLOT_LAST = 6'h1F;
    localparam logic [5:0] POS_MAX = 6'h3F;
    localparam logic [5:0] BITS16 = 6'h10;
    localparam logic [5:0] BITS18 = 6'h12;
    localparam logic [5:0] BITS20 = 6'h14;
    localparam logic [5:0] BITS24 = 6'h18;
    localparam logic [5:0] I2S_DELAY = 6'h01;
    localparam logic [5:0] NO_DELAY = 6'h00;

    // ---------------------------------------------------------------
    // timing: the source derives the bit clock from clk
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_HALF_NS = 60;
    localparam int BIT_HALF_CYC = BIT_HALF_NS / CLK_PERIOD_NS;
    localparam logic [3:0] DIV_LAST = 4'(BIT_HALF_CYC - 1);

    function automatic logic [5:0] word_bits(input width_t w);
        unique case (w)
            WID16: word_bits = BITS16;
            WID18: word_bits = BITS18;
            WID20: word_bits = BITS20;
            WID24: word_bits = BITS24;
        endcase
    endfunction : word_bits

    // bit position of the msb inside a slot, counted from the
    // first bit clock after the channel clock changes
    function automatic logic [5:0] msb_pos(input fmt_t f,
                                           input width_t w);
        unique case (f)
            FMT_I2S: msb_pos = I2S_DELAY;
            FMT_LEFT: msb_pos = NO_DELAY;
            FMT_RIGHT: msb_pos = SLOT_LEN - word_bits(w);
            default: msb_pos = I2S_DELAY;
        endcase
    endfunction : msb_pos

    // channel clock level that marks the right channel
    function automatic logic right_level(input fmt_t f);
        right_level = (f == FMT_I2S) || (f != FMT_LEFT && f != FMT_RIGHT);
    endfunction : right_level

endpackage : audio_in_pkg

// ---- verilog/audio_serial_if.sv ----
`timescale 1ns/100ps
interface audio_serial_if;
    logic bitClk;
    logic chanClk;
    logic serData;

    modport source (
        output bitClk,
        output chanClk,
        output serData
    );

    modport sink (
        input bitClk,
        input chanClk,
        input serData
    );
endinterface : audio_serial_if

// ---- verilog/serial_audio_source.sv ----
`timescale 1ns/100ps
module serial_audio_source (
    input wire logic clk,
    input wire logic nrst,
    audio_serial_if.source link,
    input wire audio_in_pkg::fmt_t fmt,
    input wire audio_in_pkg::width_t wordSel,
    input wire logic [23:0] leftIn,
    input wire logic [23:0] rightIn,
    input wire logic inValid,
    output logic inReady
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0] div;
        logic bclk;
        logic isRight;
        logic [5:0] pos;
        audio_in_pkg::fmt_t curFmt;
        audio_in_pkg::width_t curWid;
        logic [23:0] curL;
        logic [23:0] curR;
        logic pendFull;
        logic [23:0] pendL;
        logic [23:0] pendR;
        logic lrOut;
        logic datOut;
    } src_t;

    src_t st_ff;
    src_t nxt_st;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [5:0] off;
        logic [5:0] k;
        logic [23:0] word;
        nxt_st = st_ff;
        off = 6'h00;
        k = 6'h00;
        word = 24'h000000;
        if (st_ff.div == audio_in_pkg::DIV_LAST) begin
            nxt_st.div = 4'h0;
            nxt_st.bclk = !st_ff.bclk;
            // outputs move on the falling edge so they are steady at rise
            if (st_ff.bclk) begin
                if (st_ff.pos == audio_in_pkg::SLOT_LAST) begin
                    nxt_st.pos = 6'h00;
                    nxt_st.isRight = !st_ff.isRight;
                    if (st_ff.isRight) begin
                        // frame start: config and samples change only here
                        nxt_st.curFmt = fmt;
                        nxt_st.curWid = wordSel;
                        nxt_st.curL = st_ff.pendFull ? st_ff.pendL : 24'h0;
                        nxt_st.curR = st_ff.pendFull ? st_ff.pendR : 24'h0;
                        nxt_st.pendFull = 1'b0;
                    end
                end else begin
                    nxt_st.pos = st_ff.pos + 6'h01;
                end
                off = audio_in_pkg::msb_pos(nxt_st.curFmt, nxt_st.curWid);
                k = nxt_st.pos - off;
                word = nxt_st.isRight ? nxt_st.curR : nxt_st.curL;
                nxt_st.lrOut = nxt_st.isRight ==
                    audio_in_pkg::right_level(nxt_st.curFmt);
                // msb first from the format's start bit; the rest idle low
                if (nxt_st.pos >= off && k <
                        audio_in_pkg::word_bits(nxt_st.curWid)) begin
                    nxt_st.datOut = word[audio_in_pkg::MSB_IDX - k[4:0]];
                end else begin
                    nxt_st.datOut = 1'b0;
                end
            end
        end else begin
            nxt_st.div = st_ff.div + 4'h1;
        end
        if (inValid && !st_ff.pendFull) begin
            nxt_st.pendFull = 1'b1;
            nxt_st.pendL = leftIn;
            nxt_st.pendR = rightIn;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{div: 4'h0, bclk: 1'b0, isRight: 1'b1,
                       pos: audio_in_pkg::SLOT_LAST,
                       curFmt: audio_in_pkg::FMT_I2S,
                       curWid: audio_in_pkg::WID24,
                       curL: 24'h0, curR: 24'h0, pendFull: 1'b0,
                       pendL: 24'h0, pendR: 24'h0, lrOut: 1'b1,
                       datOut: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.bitClk = st_ff.bclk;
    assign link.chanClk = st_ff.lrOut;
    assign link.serData = st_ff.datOut;
    assign inReady = !st_ff.pendFull;

endmodule : serial_audio_source

// ---- verilog/serial_audio_sink.sv ----
`timescale 1ns/100ps
module serial_audio_sink (
    input wire logic clk,
    input wire logic nrst,
    audio_serial_if.sink link,
    input wire audio_in_pkg::fmt_t fmt,
    input wire audio_in_pkg::width_t wordSel,
    output logic pairValid,
    input wire logic pairReady,
    output logic [23:0] leftOut,
    output logic [23:0] rightOut,
    output logic bufFull,
    output logic overrun
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    // the buffer is two entries: head feeds the ports straight from
    // flops, tail catches a pair that lands while head is stalled
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic bclkPrev;
        logic lrPrev;
        logic [5:0] pos;
        logic [23:0] shL;
        logic [23:0] shR;
        logic leftDone;
        logic headV;
        logic [23:0] headL;
        logic [23:0] headR;
        logic tailV;
        logic [23:0] tailL;
        logic [23:0] tailR;
        logic ovr;
    } snk_t;

    snk_t st_ff;
    snk_t nxt_st;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic bclk;
        logic lr;
        logic dat;
        logic rightCh;
        logic push;
        logic [5:0] off;
        logic [5:0] wbits;
        logic [5:0] k;
        nxt_st = st_ff;
        bclk = st_ff.sync[2];
        lr = st_ff.sync[1];
        dat = st_ff.sync[0];
        rightCh = 1'b0;
        push = 1'b0;
        off = audio_in_pkg::msb_pos(fmt, wordSel);
        wbits = audio_in_pkg::word_bits(wordSel);
        k = 6'h00;
        nxt_st.ovr = 1'b0;

        // two flops on every pin before any logic looks at it
        nxt_st.meta = {link.bitClk, link.chanClk, link.serData};
        nxt_st.sync = st_ff.meta;
        nxt_st.bclkPrev = bclk;

        if (bclk && !st_ff.bclkPrev) begin
            nxt_st.lrPrev = lr;
            rightCh = lr == audio_in_pkg::right_level(fmt);
            // a channel clock change marks bit zero of a new slot
            if (lr != st_ff.lrPrev) begin
                k = 6'h00;
            end else if (st_ff.pos != audio_in_pkg::POS_MAX) begin
                k = st_ff.pos + 6'h01;
            end else begin
                k = st_ff.pos;
            end
            nxt_st.pos = k;
            if (k == 6'h00 && !rightCh) begin
                nxt_st.shL = 24'h0;
                nxt_st.leftDone = 1'b0;
            end
            if (k == 6'h00 && rightCh) begin
                nxt_st.shR = 24'h0;
            end
            k = k - off;
            // outside the word window the line is don't-care
            if (nxt_st.pos >= off && k < wbits) begin
                if (rightCh) begin
                    nxt_st.shR[audio_in_pkg::MSB_IDX - k[4:0]] = dat;
                end else begin
                    nxt_st.shL[audio_in_pkg::MSB_IDX - k[4:0]] = dat;
                end
                if (k == wbits - 6'h01) begin
                    if (!rightCh) begin
                        nxt_st.leftDone = 1'b1;
                    end else if (st_ff.leftDone) begin
                        push = 1'b1;
                        nxt_st.leftDone = 1'b0;
                    end
                end
            end
        end

        // ---------------------------------------------------------------
        // two-entry output buffer
        // ---------------------------------------------------------------
        if (st_ff.headV && pairReady) begin
            nxt_st.headV = st_ff.tailV;
            nxt_st.headL = st_ff.tailL;
            nxt_st.headR = st_ff.tailR;
            nxt_st.tailV = 1'b0;
        end
        if (push) begin
            // the encoder cannot stall the serial line, so a third pair
            // is dropped and flagged rather than corrupting the buffer
            if (!nxt_st.headV) begin
                nxt_st.headV = 1'b1;
                nxt_st.headL = nxt_st.shL;
                nxt_st.headR = nxt_st.shR;
            end else if (!nxt_st.tailV) begin
                nxt_st.tailV = 1'b1;
                nxt_st.tailL = nxt_st.shL;
                nxt_st.tailR = nxt_st.shR;
            end else begin
                nxt_st.ovr = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // idle link levels: channel clock rests high, so no false
            // slot start is seen on the first bit clock after reset
            st_ff <= '{meta: 3'h2, sync: 3'h2, bclkPrev: 1'b0,
                       lrPrev: 1'b1, pos: audio_in_pkg::POS_MAX,
                       shL: 24'h0, shR: 24'h0, leftDone: 1'b0,
                       headV: 1'b0, headL: 24'h0, headR: 24'h0,
                       tailV: 1'b0, tailL: 24'h0, tailR: 24'h0,
                       ovr: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pairValid = st_ff.headV;
    assign leftOut = st_ff.headL;
    assign rightOut = st_ff.headR;
    assign bufFull = st_ff.tailV;
    assign overrun = st_ff.ovr;

endmodule : serial_audio_sink

// ---- sim/audio_link_assertions.sv ----
`timescale 1ns/100ps
module audio_link_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bitClk,
    input wire logic chanClk,
    input wire logic serData
);
    localparam int SLOT_CYC = 384;
    logic bitPrev_ff;
    logic chanPrev_ff;
    logic synced_ff;
    logic [5:0] rises_ff;
    logic bitRise;
    logic chanEdge;
    assign bitRise = bitClk & ~bitPrev_ff;
    assign chanEdge = chanClk ^ chanPrev_ff;
    // slot length is only known once a first channel edge is seen
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitPrev_ff <= 1'b0;
            chanPrev_ff <= 1'b1;
            synced_ff <= 1'b0;
            rises_ff <= 6'h00;
        end else begin
            bitPrev_ff <= bitClk;
            chanPrev_ff <= chanClk;
            synced_ff <= synced_ff | chanEdge;
            rises_ff <= chanEdge ? 6'h00 : rises_ff + {5'h00, bitRise};
        end
    end
    // ---------------------------------------------------------------
    // link timing
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence highPhase; bitClk [*6]; endsequence
    sequence lowPhase; !bitClk [*6]; endsequence
    AST_BIT_HIGH: assert property (
        $rose(bitClk) |-> highPhase ##1 !bitClk)
        else $error("bit clock high phase wrong");
    AST_BIT_LOW: assert property ($fell(bitClk) |-> lowPhase ##1 bitClk)
        else $error("bit clock low phase wrong");
    AST_RISE_PERIOD: assert property (
        $rose(bitClk) |-> ##12 $rose(bitClk))
        else $error("bit clock period wrong");
    AST_CHAN_ON_FALL: assert property (
        $changed(chanClk) |-> $fell(bitClk))
        else $error("channel clock moved off a falling bit edge");
    AST_DATA_ON_FALL: assert property (
        $changed(serData) |-> $fell(bitClk))
        else $error("data moved off a falling bit edge");
    AST_SLOT_BITS: assert property (
        chanEdge && synced_ff |-> rises_ff == 6'h20)
        else $error("slot does not hold 32 bit clocks");
    AST_SLOT_SPAN: assert property (chanEdge && synced_ff |->
        ##[SLOT_CYC:SLOT_CYC] chanEdge)
        else $error("slot span wrong");
    AST_START_IDLE: assert property ($rose(nrst) |->
        (!bitClk && chanClk) [*4] ##[1:4] bitClk)
        else $error("link start after reset wrong");
endmodule : audio_link_assertions

// ---- sim/tb_spdif_tx_serial_input_format.sv ----
`timescale 1ns/100ps
module tb_spdif_tx_serial_input_format;
    logic clk, nrst, inValid, inReady, pairValid, pairReady, bufFull, overrun;
    audio_in_pkg::fmt_t fmt, f;
    audio_in_pkg::width_t wordSel, w;
    logic [23:0] leftIn, rightIn, leftOut, rightOut, l, r;
    int n_errors, n_compared, ovCnt;
    audio_serial_if link ();
    serial_audio_source serial_audio_source_inst (.clk(clk), .nrst(nrst),
        .link(link), .fmt(fmt), .wordSel(wordSel), .leftIn(leftIn),
        .rightIn(rightIn), .inValid(inValid), .inReady(inReady));
    serial_audio_sink serial_audio_sink_inst (.clk(clk), .nrst(nrst),
        .link(link), .fmt(fmt), .wordSel(wordSel), .pairValid(pairValid),
        .pairReady(pairReady), .leftOut(leftOut), .rightOut(rightOut),
        .bufFull(bufFull), .overrun(overrun));
    audio_link_assertions audio_link_assertions_inst (.clk(clk),
        .nrst(nrst), .bitClk(link.bitClk), .chanClk(link.chanClk),
        .serData(link.serData));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (overrun === 1'b1) ovCnt = ovCnt + 1;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [23:0] keep(input audio_in_pkg::width_t x);
        case (x)
            audio_in_pkg::WID16: keep = 24'hFFFF00;
            audio_in_pkg::WID18: keep = 24'hFFFFC0;
            audio_in_pkg::WID20: keep = 24'hFFFFF0;
            default: keep = 24'hFFFFFF;
        endcase
    endfunction : keep
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic do_reset(input audio_in_pkg::fmt_t a,
                            input audio_in_pkg::width_t b);
        @(posedge clk);
        nrst <= 1'b0;
        fmt <= a;
        wordSel <= b;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ovCnt = 0;
    endtask : do_reset
    task automatic send(input logic [23:0] a, input logic [23:0] b);
        int k;
        k = 0;
        @(posedge clk);
        while (inReady !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        check({31'h0, inReady}, 32'h1);
        inValid <= 1'b1;
        leftIn <= a;
        rightIn <= b;
        @(posedge clk);
        inValid <= 1'b0;
    endtask : send
    task automatic recv(input logic [23:0] a, input logic [23:0] b);
        int k;
        k = 0;
        @(posedge clk);
        while (pairValid !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        pairReady <= 1'b1;
        check({31'h0, pairValid}, 32'h1);
        check({8'h00, leftOut}, {8'h00, a});
        check({8'h00, rightOut}, {8'h00, b});
        @(posedge clk);
        pairReady <= 1'b0;
    endtask : recv
    // one slot off the wire, checked for level, msb place and width
    task automatic cap_slot;
        logic lvl, pb;
        logic [31:0] s;
        int k, p;
        lvl = link.chanClk;
        k = 0;
        while (link.chanClk === lvl && k < 1000) begin
            @(posedge clk);
            k++;
        end
        lvl = link.chanClk;
        pb = link.bitClk;
        s = 32'h0;
        k = 0;
        while (k < 32) begin
            @(posedge clk);
            if (link.bitClk && !pb) begin
                s = {s[30:0], link.serData};
                k++;
            end
            pb = link.bitClk;
        end
        p = (f == audio_in_pkg::FMT_LEFT) ? 0 :
            (f == audio_in_pkg::FMT_RIGHT) ? 32 - $countones(keep(w)) : 1;
        check(s, {((lvl == (f == audio_in_pkg::FMT_LEFT ||
            f == audio_in_pkg::FMT_RIGHT)) ? l : r) & keep(w),
            8'h00} >> p);
    endtask : cap_slot
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        inValid = 1'b0;
        pairReady = 1'b0;
        fmt = audio_in_pkg::FMT_I2S;
        wordSel = audio_in_pkg::WID24;
        leftIn = 24'h000000;
        rightIn = 24'h000000;
        n_errors = 0;
        n_compared = 0;
        ovCnt = 0;
        // the unnamed code 11 must behave as the default i2s framing
        for (int fi = 0; fi < 4; fi++) begin
            for (int wi = 0; wi < 4; wi++) begin
                f = (fi == 0) ? audio_in_pkg::FMT_I2S :
                    (fi == 1) ? audio_in_pkg::FMT_LEFT :
                    (fi == 2) ? audio_in_pkg::FMT_RIGHT :
                    audio_in_pkg::fmt_t'(2'h3);
                w = audio_in_pkg::width_t'(wi);
                l = 24'h9A5C37 ^ 24'(wi);
                r = 24'h63B4D9 ^ 24'(fi * 16);
                do_reset(f, w);
                fork
                    repeat (3) send(l, r);
                    repeat (2) cap_slot();
                join
                recv(l & keep(w), r & keep(w));
                recv(l & keep(w), r & keep(w));
                $display("test fmt %0d width %0d done", fi, wi);
            end
        end
        // the stream cannot stall, so a full buffer must drop and flag
        do_reset(audio_in_pkg::FMT_I2S, audio_in_pkg::WID24);
        repeat (4) send(l, r);
        repeat (800) @(posedge clk);
        check({31'h0, bufFull}, 32'h1);
        check({31'h0, ovCnt != 0}, 32'h1);
        recv(l, r);
        recv(l, r);
        $display("test buffer done");
        end_sim();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule : tb_spdif_tx_serial_input_format
